// ===== fcsb_bank.v
// Fieldbus command/status register bank with AHB-Lite slave
// Notes on behaviour
// - Bit 0 requests ramped stop or start; bit 1 disables or enables generally.
// - Bit 2 jog, bit 3 rotation CW/CCW, bit 4 control location local/remote.
// - Fault reset only on a 0-to-1 change of bit 7 while faulted.
// - Run/stop and jog bits of inactive command sources are cleared.
// - Two independent 16-bit command words, one per accessory slot.
// - Output word bits 0..2 drive discrete outputs one to three; rest reserved.
// - Analog output is a 10-bit unsigned code, 0 to full scale.
// - Controller codes: disabled, baud detect, active, warning, passive, bus off, no power.
// - Controller reports disabled whenever no CAN protocol is selected.
// - Baud detection code only with DeviceNet selected and rate search ongoing.
// - 16-bit received-frame counter increments per frame and wraps.
// - 16-bit sent-frame counter increments per frame and wraps.
// - 16-bit counter increments on each entry into bus off.
// - 16-bit counter increments for each received frame that could not be processed.
// - Lost-frame counter clears at power-up, reset, and on the next frame after reaching maximum.
// - Link codes: disabled, reserved, enabled, error control active, guard error, heartbeat error.
// - Node codes: disabled, init, stopped, operational, pre-operational; stopped honours management only.
// - Initialisation blocks communication and ends by itself.
// - Pre-operational allows other traffic but no process data until started.
// - Protocol select: 0 interface off, 1 CANopen, 2 DeviceNet.
`timescale 1ns/1ps
`include "fcsb_consts.vh"
module fcsb_bank (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Protocol engine events and state
  input wire frame_rx_pulse,
  input wire frame_tx_pulse,
  input wire frame_lost_pulse,
  input wire [1:0] ctrl_err_state,
  input wire baud_search,
  input wire nmt_valid,
  input wire [2:0] nmt_cmd,
  input wire error_control_active,
  input wire guard_error,
  input wire heartbeat_error,
  // Starter side and pins
  input wire fault_active,
  input wire bus_power_pin,
  // Effective commands of the active source; fault reset from either slot
  output reg ramp_run,
  output reg general_enable,
  output reg inch_run,
  output reg rotation_direction,
  output reg control_location,
  output reg fault_reset_pulse,
  // Network driven outputs
  output reg discrete_output_one,
  output reg discrete_output_two,
  output reg discrete_output_three,
  output reg [9:0] network_analog_output_code,
  // Communication permissions
  output reg service_data_enable,
  output reg process_data_enable
);
  localparam [31:0] INIT_CYCLES = `FCSB_INIT_CYCLES;
  // Bus pipeline
  reg wr_pend_r;
  reg [11:0] wr_addr_r;
  wire addr_phase;
  // Writable registers
  reg [15:0] slot_one_command_word_r;
  reg [15:0] slot_one_command_word_nxt;
  reg [15:0] slot_two_command_word_r;
  reg [15:0] slot_two_command_word_nxt;
  reg [15:0] network_digital_output_word_r;
  reg [15:0] network_digital_output_word_nxt;
  reg [9:0] network_analog_output_code_r;
  reg [9:0] network_analog_output_code_nxt;
  reg [1:0] bus_protocol_select_r;
  reg [1:0] bus_protocol_select_nxt;
  reg [1:0] command_source_r;
  reg [1:0] command_source_nxt;
  // Status
  reg [15:0] received_frame_count_r;
  reg [15:0] sent_frame_count_r;
  reg [15:0] bus_off_event_count_r;
  reg [15:0] dropped_frame_count_r;
  reg [1:0] err_prev_r;
  reg [2:0] bus_controller_state;
  reg [2:0] protocol_link_state;
  reg [2:0] slave_node_state_r;
  reg [2:0] slave_node_state_nxt;
  reg [9:0] init_cnt_r;
  reg [9:0] init_cnt_nxt;
  reg [15:0] active_cmd;
  reg [31:0] rdata_nxt;
  wire bus_power_ok;
  wire canopen_sel;

  ////////////////////////////////////////////////////////////////
  // Supply sense pin comes from outside the clock domain
  fcsb_sync u_power_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(bus_power_pin),
    .level_out(bus_power_ok)
  );
  assign addr_phase = hsel && htrans[1] && hready;
  assign canopen_sel = (bus_protocol_select_r == `FCSB_PROTO_COPEN);
  ////////////////////////////////////////////////////////////////
  // Address phase capture; writes land one cycle later with hwdata
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_r <= haddr[11:0];
      end
      hreadyout <= 1'b1; // Never stalls, always OKAY
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Next values of the writable registers
  always @* begin
    slot_one_command_word_nxt = slot_one_command_word_r;
    slot_two_command_word_nxt = slot_two_command_word_r;
    network_digital_output_word_nxt = network_digital_output_word_r;
    network_analog_output_code_nxt = network_analog_output_code_r;
    bus_protocol_select_nxt = bus_protocol_select_r;
    command_source_nxt = command_source_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `FCSB_OFS_SLOT_ONE: begin
          slot_one_command_word_nxt = hwdata[15:0] & `FCSB_CMD_MASK;
        end
        `FCSB_OFS_SLOT_TWO: begin
          slot_two_command_word_nxt = hwdata[15:0] & `FCSB_CMD_MASK;
        end
        `FCSB_OFS_DOUT: begin
          network_digital_output_word_nxt = hwdata[15:0] & `FCSB_DOUT_MASK;
        end
        `FCSB_OFS_AOUT: network_analog_output_code_nxt = hwdata[9:0];
        `FCSB_OFS_PROTO: begin
          // Code 3 is no protocol; keep the old choice
          if (hwdata[1:0] != 2'h3) begin
            bus_protocol_select_nxt = hwdata[1:0];
          end
        end
        `FCSB_OFS_SOURCE: begin
          if (hwdata[1:0] != 2'h3) begin
            command_source_nxt = hwdata[1:0];
          end
        end
        default: slot_one_command_word_nxt = slot_one_command_word_r;
      endcase
    end
    // Inactive sources lose run and jog so a source swap cannot start the motor
    if (command_source_nxt != `FCSB_SRC_ONE) begin
      slot_one_command_word_nxt[`FCSB_CMD_RUN] = 1'b0;
      slot_one_command_word_nxt[`FCSB_CMD_INCH] = 1'b0;
    end
    if (command_source_nxt != `FCSB_SRC_TWO) begin
      slot_two_command_word_nxt[`FCSB_CMD_RUN] = 1'b0;
      slot_two_command_word_nxt[`FCSB_CMD_INCH] = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Command word of the active source
  always @* begin
    case (command_source_nxt)
      `FCSB_SRC_ONE: active_cmd = slot_one_command_word_nxt;
      `FCSB_SRC_TWO: active_cmd = slot_two_command_word_nxt;
      default: active_cmd = 16'h0000; // No source: stop and disable
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Register storage and decoded command outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_one_command_word_r <= 16'h0000;
      slot_two_command_word_r <= 16'h0000;
      network_digital_output_word_r <= 16'h0000;
      network_analog_output_code_r <= 10'h000;
      bus_protocol_select_r <= `FCSB_PROTO_RESET;
      command_source_r <= `FCSB_SRC_NONE;
      ramp_run <= 1'b0;
      general_enable <= 1'b0;
      inch_run <= 1'b0;
      rotation_direction <= 1'b0;
      control_location <= 1'b0;
      fault_reset_pulse <= 1'b0;
      discrete_output_one <= 1'b0;
      discrete_output_two <= 1'b0;
      discrete_output_three <= 1'b0;
      network_analog_output_code <= 10'h000;
    end else begin
      slot_one_command_word_r <= slot_one_command_word_nxt;
      slot_two_command_word_r <= slot_two_command_word_nxt;
      network_digital_output_word_r <= network_digital_output_word_nxt;
      network_analog_output_code_r <= network_analog_output_code_nxt;
      bus_protocol_select_r <= bus_protocol_select_nxt;
      command_source_r <= command_source_nxt;
      ramp_run <= active_cmd[`FCSB_CMD_RUN];
      general_enable <= active_cmd[`FCSB_CMD_GEN_EN];
      inch_run <= active_cmd[`FCSB_CMD_INCH];
      rotation_direction <= active_cmd[`FCSB_CMD_DIR];
      control_location <= active_cmd[`FCSB_CMD_LOC];
      // Only a rising reset bit acts; a held one does nothing
      fault_reset_pulse <= fault_active &&
        ((!slot_one_command_word_r[`FCSB_CMD_FRST] &&
          slot_one_command_word_nxt[`FCSB_CMD_FRST]) ||
         (!slot_two_command_word_r[`FCSB_CMD_FRST] &&
          slot_two_command_word_nxt[`FCSB_CMD_FRST]));
      discrete_output_one <= network_digital_output_word_nxt[0];
      discrete_output_two <= network_digital_output_word_nxt[1];
      discrete_output_three <= network_digital_output_word_nxt[2];
      network_analog_output_code <= network_analog_output_code_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Frame and event counters, all wrap at 16 bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      received_frame_count_r <= 16'h0000;
      sent_frame_count_r <= 16'h0000;
      bus_off_event_count_r <= 16'h0000;
      dropped_frame_count_r <= 16'h0000;
      err_prev_r <= 2'h0;
    end else begin
      err_prev_r <= ctrl_err_state;
      if (frame_rx_pulse) begin
        received_frame_count_r <= received_frame_count_r + 16'h0001;
      end
      if (frame_tx_pulse) begin
        sent_frame_count_r <= sent_frame_count_r + 16'h0001;
      end
      if (ctrl_err_state == `FCSB_ERR_BUS_OFF && err_prev_r != `FCSB_ERR_BUS_OFF) begin
        bus_off_event_count_r <= bus_off_event_count_r + 16'h0001;
      end
      if (frame_lost_pulse) begin
        // Maximum count rolls back to zero
        if (dropped_frame_count_r == 16'hFFFF) begin
          dropped_frame_count_r <= 16'h0000;
        end else begin
          dropped_frame_count_r <= dropped_frame_count_r + 16'h0001;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Controller and link state codes
  always @* begin
    if (bus_protocol_select_r == `FCSB_PROTO_OFF) begin
      bus_controller_state = `FCSB_CS_DISABLED;
    end else if (!bus_power_ok) begin
      bus_controller_state = `FCSB_CS_NO_POWER;
    end else if (bus_protocol_select_r == `FCSB_PROTO_DNET && baud_search) begin
      bus_controller_state = `FCSB_CS_AUTOBAUD;
    end else begin
      bus_controller_state = `FCSB_CS_ENABLED + {1'b0, ctrl_err_state};
    end
    if (!canopen_sel) begin
      protocol_link_state = `FCSB_LS_DISABLED;
    end else if (heartbeat_error) begin
      protocol_link_state = `FCSB_LS_HBEAT_ERR;
    end else if (guard_error) begin
      protocol_link_state = `FCSB_LS_GUARD_ERR;
    end else if (error_control_active) begin
      protocol_link_state = `FCSB_LS_ERR_CTRL;
    end else begin
      protocol_link_state = `FCSB_LS_ENABLED;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Slave node state machine
  always @* begin
    slave_node_state_nxt = slave_node_state_r;
    init_cnt_nxt = 10'h000;
    case (slave_node_state_r)
      `FCSB_NS_DISABLED: begin
        if (canopen_sel) begin
          slave_node_state_nxt = `FCSB_NS_INIT;
        end
      end
      `FCSB_NS_INIT: begin
        // Commands are ignored here; the stage ends on its own timer
        if (init_cnt_r == INIT_CYCLES[9:0] - 10'h001) begin
          slave_node_state_nxt = `FCSB_NS_PREOP;
        end else begin
          init_cnt_nxt = init_cnt_r + 10'h001;
        end
      end
      `FCSB_NS_STOPPED, `FCSB_NS_OPER, `FCSB_NS_PREOP: begin
        if (nmt_valid) begin
          case (nmt_cmd)
            `FCSB_NMT_START: slave_node_state_nxt = `FCSB_NS_OPER;
            `FCSB_NMT_STOP: slave_node_state_nxt = `FCSB_NS_STOPPED;
            `FCSB_NMT_PREOP: slave_node_state_nxt = `FCSB_NS_PREOP;
            `FCSB_NMT_RESET: slave_node_state_nxt = `FCSB_NS_INIT;
            default: slave_node_state_nxt = slave_node_state_r;
          endcase
        end
      end
      default: begin
        slave_node_state_nxt = `FCSB_NS_DISABLED;
      end
    endcase
    if (!canopen_sel) begin
      slave_node_state_nxt = `FCSB_NS_DISABLED;
      init_cnt_nxt = 10'h000;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Node state storage and communication permissions
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slave_node_state_r <= `FCSB_NS_DISABLED;
      init_cnt_r <= 10'h000;
      service_data_enable <= 1'b0;
      process_data_enable <= 1'b0;
    end else begin
      slave_node_state_r <= slave_node_state_nxt;
      init_cnt_r <= init_cnt_nxt;
      // Stopped keeps the node quiet but for management; init keeps it wholly quiet
      service_data_enable <= (slave_node_state_nxt == `FCSB_NS_OPER) ||
        (slave_node_state_nxt == `FCSB_NS_PREOP);
      process_data_enable <= (slave_node_state_nxt == `FCSB_NS_OPER);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Read mux; uses next values so a read right after a write sees it
  always @* begin
    rdata_nxt = 32'h00000000;
    case (haddr[11:0])
      `FCSB_OFS_SLOT_ONE: rdata_nxt[15:0] = slot_one_command_word_nxt;
      `FCSB_OFS_SLOT_TWO: rdata_nxt[15:0] = slot_two_command_word_nxt;
      `FCSB_OFS_DOUT: rdata_nxt[15:0] = network_digital_output_word_nxt;
      `FCSB_OFS_AOUT: rdata_nxt[9:0] = network_analog_output_code_nxt;
      `FCSB_OFS_PROTO: rdata_nxt[1:0] = bus_protocol_select_nxt;
      `FCSB_OFS_SOURCE: rdata_nxt[1:0] = command_source_nxt;
      `FCSB_OFS_CTRL_STATE: rdata_nxt[2:0] = bus_controller_state;
      `FCSB_OFS_RX_CNT: rdata_nxt[15:0] = received_frame_count_r;
      `FCSB_OFS_TX_CNT: rdata_nxt[15:0] = sent_frame_count_r;
      `FCSB_OFS_BOFF_CNT: rdata_nxt[15:0] = bus_off_event_count_r;
      `FCSB_OFS_LOST_CNT: rdata_nxt[15:0] = dropped_frame_count_r;
      `FCSB_OFS_LINK_STATE: rdata_nxt[2:0] = protocol_link_state;
      `FCSB_OFS_NODE_STATE: rdata_nxt[2:0] = slave_node_state_r;
      default: rdata_nxt = 32'h00000000; // Unmapped reads return zero
    endcase
  end
endmodule // fcsb_bank

// ===== fcsb_bank_asserts.sv
// Port checks of the fieldbus command/status bank
`timescale 1ns/1ps
module fcsb_bank_asserts (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // Starter side and network
  input wire fault_active,
  input wire nmt_valid,
  input wire [2:0] nmt_cmd,
  // Outputs watched
  input wire ramp_run,
  input wire inch_run,
  input wire fault_reset_pulse,
  input wire discrete_output_one,
  input wire discrete_output_two,
  input wire discrete_output_three,
  input wire [9:0] network_analog_output_code,
  input wire service_data_enable,
  input wire process_data_enable
);
  logic wr_r;
  logic [11:0] adr_r;
  wire take = hsel && htrans[1] && hready;
  wire [2:0] dos = {discrete_output_three, discrete_output_two, discrete_output_one};
  ////////////////////////////////////////////////////////////////
  // Data phase of a write; stores land at its closing edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      adr_r <= 12'h000;
    end else begin
      wr_r <= take && hwrite;
      adr_r <= haddr[11:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////
  property p_frst_one;
    fault_reset_pulse |=> !fault_reset_pulse;
  endproperty
  a_frst_one: assert property (p_frst_one) else $error("fault reset too wide");
  property p_frst_src;
    fault_reset_pulse |-> $past(fault_active) && $past(wr_r) && $past(hwdata[7])
      && ($past(adr_r) inside {12'h000, 12'h004});
  endproperty
  a_frst_src: assert property (p_frst_src) else $error("fault reset without cause");
  property p_cmd_cause;
    $past(hresetn) && ($changed(ramp_run) || $changed(inch_run)) |->
      $past(wr_r) && $past(adr_r) inside {12'h000, 12'h004, 12'h014};
  endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("run or jog moved alone");
  property p_dout_wr;
    wr_r && adr_r == 12'h008 |=> dos == $past(hwdata[2:0]);
  endproperty
  a_dout_wr: assert property (p_dout_wr) else $error("discrete outputs wrong");
  property p_ao_wr;
    wr_r && adr_r == 12'h00C |=> network_analog_output_code == $past(hwdata[9:0]);
  endproperty
  a_ao_wr: assert property (p_ao_wr) else $error("analog code wrong");
  property p_out_hold;
    !(wr_r && adr_r[11:3] == 9'h001) |=> $stable({dos, network_analog_output_code});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outputs moved alone");
  property p_pdo_sdo;
    process_data_enable |-> service_data_enable;
  endproperty
  a_pdo_sdo: assert property (p_pdo_sdo) else $error("process data alone");
  property p_pdo_start;
    $rose(process_data_enable) |-> $past(nmt_valid) && $past(nmt_cmd) == 3'h1;
  endproperty
  a_pdo_start: assert property (p_pdo_start) else $error("process data not started");
  property p_rdata_hold;
    !(take && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // Main scenarios reached
  c_frst: cover property (fault_reset_pulse);
  c_pdo: cover property ($rose(process_data_enable));
  c_dout: cover property (wr_r && adr_r == 12'h008);
  c_read: cover property (take && !hwrite);
endmodule // fcsb_bank_asserts
bind fcsb_bank fcsb_bank_asserts u_asserts (.*);

// ===== fcsb_consts.vh
// Offsets, fields, codes and timing of the command/status bank
`ifndef FCSB_CONSTS_VH
`define FCSB_CONSTS_VH

// Register byte offsets
`define FCSB_OFS_SLOT_ONE 12'h000
`define FCSB_OFS_SLOT_TWO 12'h004
`define FCSB_OFS_DOUT 12'h008
`define FCSB_OFS_AOUT 12'h00C
`define FCSB_OFS_PROTO 12'h010
`define FCSB_OFS_SOURCE 12'h014
`define FCSB_OFS_CTRL_STATE 12'h018
`define FCSB_OFS_RX_CNT 12'h01C
`define FCSB_OFS_TX_CNT 12'h020
`define FCSB_OFS_BOFF_CNT 12'h024
`define FCSB_OFS_LOST_CNT 12'h028
`define FCSB_OFS_LINK_STATE 12'h02C
`define FCSB_OFS_NODE_STATE 12'h030

// Command word fields
`define FCSB_CMD_RUN 0
`define FCSB_CMD_GEN_EN 1
`define FCSB_CMD_INCH 2
`define FCSB_CMD_DIR 3
`define FCSB_CMD_LOC 4
`define FCSB_CMD_FRST 7
`define FCSB_CMD_MASK 16'h009F
`define FCSB_DOUT_MASK 16'h0007

// Command source select
`define FCSB_SRC_NONE 2'h0
`define FCSB_SRC_ONE 2'h1
`define FCSB_SRC_TWO 2'h2

// Protocol select codes and reset value
`define FCSB_PROTO_OFF 2'h0
`define FCSB_PROTO_COPEN 2'h1
`define FCSB_PROTO_DNET 2'h2
`define FCSB_PROTO_RESET 2'h2

// Controller state codes
`define FCSB_CS_DISABLED 3'h0
`define FCSB_CS_AUTOBAUD 3'h1
`define FCSB_CS_ENABLED 3'h2
`define FCSB_CS_NO_POWER 3'h6

// Error state from the protocol engine
`define FCSB_ERR_BUS_OFF 2'h3

// Link state codes
`define FCSB_LS_DISABLED 3'h0
`define FCSB_LS_ENABLED 3'h2
`define FCSB_LS_ERR_CTRL 3'h3
`define FCSB_LS_GUARD_ERR 3'h4
`define FCSB_LS_HBEAT_ERR 3'h5

// Slave node state codes
`define FCSB_NS_DISABLED 3'h0
`define FCSB_NS_INIT 3'h1
`define FCSB_NS_STOPPED 3'h2
`define FCSB_NS_OPER 3'h3
`define FCSB_NS_PREOP 3'h4

// Network management commands
`define FCSB_NMT_START 3'h1
`define FCSB_NMT_STOP 3'h2
`define FCSB_NMT_PREOP 3'h3
`define FCSB_NMT_RESET 3'h4

// Timing
`define FCSB_CLK_PERIOD_NS 10
`define FCSB_INIT_TIME_NS 1000
`define FCSB_INIT_CYCLES ((`FCSB_INIT_TIME_NS + `FCSB_CLK_PERIOD_NS - 1) / `FCSB_CLK_PERIOD_NS)

`endif

// ===== fcsb_net_model.sv
// Network side model: frame events and management commands
`timescale 1ns/1ps
module fcsb_net_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request kinds: 0 rx, 1 tx, 2 lost, 8 + management command
  input wire logic req,
  input wire logic [3:0] kind,
  // Toward the bank
  output logic frame_rx_pulse,
  output logic frame_tx_pulse,
  output logic frame_lost_pulse,
  output logic nmt_valid,
  output logic [2:0] nmt_cmd
);
  // Held request: one event per cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_rx_pulse <= 1'b0;
      frame_tx_pulse <= 1'b0;
      frame_lost_pulse <= 1'b0;
      nmt_valid <= 1'b0;
      nmt_cmd <= 3'h0;
    end else begin
      frame_rx_pulse <= req && kind == 4'h0;
      frame_tx_pulse <= req && kind == 4'h1;
      frame_lost_pulse <= req && kind == 4'h2;
      nmt_valid <= req && kind[3];
      nmt_cmd <= (req && kind[3]) ? kind[2:0] : ~nmt_cmd; // Never a steady stale code
    end
  end
endmodule // fcsb_net_model

// ===== fcsb_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fcsb_sync (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Raw pin and filtered level
  input wire pin_in,
  output reg level_out
);
  reg stage1_r;
  reg stage2_r;
  reg stage3_r;

  ////////////////////////////////////////////////////////////////
  // First stage is only read by the second, to contain metastability
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
      level_out <= 1'b0;
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r) begin
        level_out <= stage3_r; // Change counts once two stages agree
      end
    end
  end
endmodule // fcsb_sync

// ===== fieldbus_command_status_bank_tb.sv
// Self-checking bench of the fieldbus command/status bank
`timescale 1ns/1ps
`include "fcsb_consts.vh"
module fieldbus_command_status_bank_tb;
  typedef struct packed {logic [11:0] a; logic [31:0] d, e; logic [7:0] o; logic [9:0] ao;} fcsb_row_t;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, req = 0;
  logic [2:0] hsize = 3'h2;
  logic [1:0] htrans = 2'h0, ctrl_err_state = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [3:0] kind = 4'h0;
  logic baud_search = 0, error_control_active = 0, guard_error = 0, heartbeat_error = 0;
  logic fault_active = 0, bus_power_pin = 1;
  wire [31:0] hrdata;
  wire [9:0] network_analog_output_code;
  wire [2:0] nmt_cmd;
  wire hreadyout, hresp, frame_rx_pulse, frame_tx_pulse, frame_lost_pulse, nmt_valid;
  wire hready = hreadyout;
  wire ramp_run, general_enable, inch_run, rotation_direction, control_location;
  wire fault_reset_pulse, service_data_enable, process_data_enable;
  wire discrete_output_one, discrete_output_two, discrete_output_three;
  wire [7:0] outs = {ramp_run, general_enable, inch_run, rotation_direction, control_location,
    discrete_output_three, discrete_output_two, discrete_output_one};
  int fails = 0, compares = 0, npulse = 0;
  fcsb_row_t rows [11] = '{
    '{12'h014, 32'h1, 32'h1, 8'h00, 10'h000}, '{12'h000, 32'hFFFF, 32'h9F, 8'hF8, 10'h000},
    '{12'h004, 32'hFFFF, 32'h9A, 8'hF8, 10'h000}, '{12'h008, 32'hFFFF, 32'h7, 8'hFF, 10'h000},
    '{12'h00C, 32'hFFFFFFFF, 32'h3FF, 8'hFF, 10'h3FF}, '{12'h010, 32'h3, 32'h2, 8'hFF, 10'h3FF},
    '{12'h014, 32'h2, 32'h2, 8'h5F, 10'h3FF}, '{12'h004, 32'h5, 32'h5, 8'hA7, 10'h3FF},
    '{12'h040, 32'h1234, 32'h0, 8'hA7, 10'h3FF}, '{12'h01C, 32'h5, 32'h0, 8'hA7, 10'h3FF},
    '{12'h014, 32'h0, 32'h0, 8'h07, 10'h3FF}};
  // Protocol, error, search, supply, code
  logic [8:0] ct [8] = '{9'b10_00_0_1_010, 9'b10_01_0_1_011, 9'b10_10_0_1_100, 9'b10_11_0_1_101,
    9'b10_11_1_1_001, 9'b01_00_1_1_010, 9'b10_00_0_0_110, 9'b00_01_1_0_000};
  // Fault level, command byte; two rises meet a fault
  logic [8:0] fs [8] = '{9'h000, 9'h180, 9'h180, 9'h100, 9'h080, 9'h000, 9'h100, 9'h181};
  logic [6:0] nm [4] = '{7'h4B, 7'h52, 7'h5C, 7'h61};
  logic [3:0] lk [4] = '{4'h0, 4'h8, 4'hC, 4'hF};
  fcsb_bank dut (.*);
  fcsb_net_model u_net (.*);
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (fault_reset_pulse === 1'b1) npulse <= npulse + 1;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for ready; a hang ends the run
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r);
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    wait_rdy();
    r = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(nm, r, e);
  endtask
  task automatic ev(input logic [3:0] k, input int n);
    kind <= k;
    req <= 1'b1;
    repeat (n) @(posedge hclk);
    req <= 1'b0;
    @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`FCSB_OFS_PROTO, 32'h2, "proto_reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "readback");
      chk("outputs", 32'(outs), 32'(rows[i].o));
      chk("analog", 32'(network_analog_output_code), 32'(rows[i].ao));
    end
    foreach (ct[i]) begin
      wr(`FCSB_OFS_PROTO, 32'(ct[i][8:7]));
      ctrl_err_state <= ct[i][6:5];
      baud_search <= ct[i][4];
      bus_power_pin <= ct[i][3];
      repeat (8) @(posedge hclk);
      rd(`FCSB_OFS_CTRL_STATE, 32'(ct[i][2:0]), "ctrl_state");
    end
    bus_power_pin <= 1'b1;
    ctrl_err_state <= 2'h3;
    repeat (2) @(posedge hclk);
    ctrl_err_state <= 2'h0;
    rd(`FCSB_OFS_BOFF_CNT, 32'h2, "bus_off_count");
    ev(4'h0, 3);
    ev(4'h1, 2);
    ev(4'h2, 1);
    rd(`FCSB_OFS_RX_CNT, 32'h3, "rx_count");
    rd(`FCSB_OFS_TX_CNT, 32'h2, "tx_count");
    rd(`FCSB_OFS_LOST_CNT, 32'h1, "lost_count");
    ev(4'h2, 65535);
    rd(`FCSB_OFS_LOST_CNT, 32'h0, "lost_wrap");
    wr(`FCSB_OFS_SOURCE, 32'h1);
    foreach (fs[i]) begin
      fault_active <= fs[i][8];
      wr(`FCSB_OFS_SLOT_ONE, 32'(fs[i][7:0]));
    end
    repeat (2) @(posedge hclk);
    chk("fault_resets", 32'(npulse), 32'h2);
    chk("ramp_run", 32'(ramp_run), 32'h1);
    wr(`FCSB_OFS_PROTO, 32'h1);
    @(posedge hclk); // Init is entered an edge after the store
    rd(`FCSB_OFS_NODE_STATE, 32'h1, "node_init");
    ev(4'h9, 1);
    rd(`FCSB_OFS_NODE_STATE, 32'h1, "init_ignores");
    chk("sdo_init", 32'(service_data_enable), 32'h0);
    foreach (lk[i]) begin
      {error_control_active, guard_error, heartbeat_error} <= lk[i][3:1];
      repeat (2) @(posedge hclk);
      rd(`FCSB_OFS_LINK_STATE, 32'h2 + i, "link_state");
    end
    repeat (110) @(posedge hclk);
    rd(`FCSB_OFS_NODE_STATE, 32'h4, "node_preop");
    chk("pdo_preop", 32'(process_data_enable), 32'h0);
    foreach (nm[i]) begin
      ev(nm[i][6:3], 1);
      rd(`FCSB_OFS_NODE_STATE, 32'(nm[i][2:0]), "node_nmt");
      chk("sdo", 32'(service_data_enable), 32'(nm[i][2:0] inside {3'h3, 3'h4}));
      chk("pdo", 32'(process_data_enable), 32'(nm[i][2:0] == 3'h3));
    end
    wr(`FCSB_OFS_PROTO, 32'h0);
    rd(`FCSB_OFS_LINK_STATE, 32'h0, "link_off");
    rd(`FCSB_OFS_NODE_STATE, 32'h0, "node_off");
    // Mid-run reset, with a lost frame counted first
    ev(4'h2, 1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("reset_outs", {23'h0, hreadyout, outs}, 32'h100);
    hresetn <= 1'b1;
    rd(`FCSB_OFS_PROTO, 32'h2, "proto_reset");
    rd(`FCSB_OFS_SLOT_ONE, 32'h0, "slot_reset");
    rd(`FCSB_OFS_LOST_CNT, 32'h0, "lost_reset");
    give_verdict();
  end
endmodule // fieldbus_command_status_bank_tb
